// ==== verilog/rxc_rx_config.sv ====
// Purpose: Receiver configuration register bank with AHB-Lite slave port
// Assumes: Receiver status inputs come from logic on clk; one cycle answer
// Notes:   Also holds sync word matcher and onoff floor decrement timing
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps

module rxc_rx_config (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Receiver status
	input  wire logic [7:0]  strength_in,
	input  wire logic        ook_rx_mode,
	input  wire logic        continuous_rx_mode,
	input  wire logic        rx_bit,
	input  wire logic        rx_bit_valid,
	input  wire logic [31:0] sync_word,
	input  wire logic        chip_tick,
	input  wire logic        chip_sub_tick,
	// Filter settings
	output logic [3:0]       lowpass_bw_sel,
	output logic [3:0]       channel_filter_cut,
	output logic [3:0]       image_filter_centre,
	output logic             image_filter_on,
	// Demodulator control
	output logic             bitsync_active,
	output logic             sync_match,
	output logic             strength_above,
	output logic [3:0]       onoff_floor_step,
	output logic             onoff_floor_dec,
	output logic [1:0]       onoff_average_cutoff
);

	// ======================================================================
	// Functions

	// Map a byte address onto a register slot, valid flag in bit 3
	function automatic logic [3:0] slot_of(input logic [31:0] a);
		logic [7:0] i;
		i = a[9:2];
		if (a[31:10] != 22'h000000 || a[1:0] != 2'h0) begin
			slot_of = 4'h0;
		end else if (i < rxc_pkg::RXC_IDX_FIRST || i > rxc_pkg::RXC_IDX_LAST) begin
			slot_of = 4'h0;
		end else begin
			slot_of = {1'b1, 3'(i - rxc_pkg::RXC_IDX_FIRST)};
		end
	endfunction : slot_of

	// Number of ones in a word
	function automatic logic [5:0] ones(input logic [31:0] v);
		logic [5:0] n;
		n = 6'h00;
		for (int k = 0; k < 32; k++) begin
			n = n + {5'h00, v[k]};
		end
		ones = n;
	endfunction : ones

	// Step code to half-dB units: 0.5,1,1.5,2,3,4,5,6 dB
	function automatic logic [3:0] step_half_db(input logic [2:0] c);
		case (c)
			3'h0:    step_half_db = 4'h1;
			3'h1:    step_half_db = 4'h2;
			3'h2:    step_half_db = 4'h3;
			3'h3:    step_half_db = 4'h4;
			3'h4:    step_half_db = 4'h6;
			3'h5:    step_half_db = 4'h8;
			3'h6:    step_half_db = 4'hA;
			default: step_half_db = 4'hC;
		endcase
	endfunction : step_half_db

	// ======================================================================
	// Register storage and bus state
	// Slot count kept local so the array bounds read plainly
	localparam int       RXC_NREG_L = rxc_pkg::RXC_NREG;
	logic [7:0]          regs_q [RXC_NREG_L];
	logic [7:0]          regs_d [RXC_NREG_L];
	rxc_pkg::rxc_req_t   req_q;
	rxc_pkg::rxc_req_t   req_d;
	logic [31:0]         hrdata_d;
	logic [3:0]          aslot;
	logic                aphase;

	// Address phase accepted on a NONSEQ seen with hsel and hready high
	always_comb begin
		aslot  = slot_of(haddr);
		aphase = hsel && hready && (htrans == rxc_pkg::RXC_HTRANS_NONSEQ);
	end

	// Next register values: data phase of a captured write
	always_comb begin
		req_d.wr  = aphase && hwrite && aslot[3];
		req_d.idx = {5'h00, aslot[2:0]};
		for (int k = 0; k < RXC_NREG_L; k++) begin
			regs_d[k] = regs_q[k];
		end
		if (req_q.wr && req_q.idx[2:0] != 3'(rxc_pkg::RXC_IDX_STRENGTH - rxc_pkg::RXC_IDX_FIRST)) begin
			regs_d[req_q.idx[2:0]] = hwdata[7:0];
		end
	end

	// Read data from next values so a write followed by a read returns new data
	// Unmapped reads answer zero; the strength slot bypasses storage
	always_comb begin
		hrdata_d = hrdata;
		if (aphase && !hwrite) begin
			hrdata_d = 32'h00000000;
			if (aslot[3]) begin
				if (aslot[2:0] == 3'(rxc_pkg::RXC_IDX_STRENGTH - rxc_pkg::RXC_IDX_FIRST)) begin
					hrdata_d = {24'h000000, strength_in};
				end else begin
					hrdata_d = {24'h000000, regs_d[aslot[2:0]]};
				end
			end
		end
	end

	// Bus and register flops
	always_ff @(posedge clk) begin
		if (!rstn) begin
			regs_q[0]  <= rxc_pkg::RXC_RST_ALERT;
			regs_q[1]  <= rxc_pkg::RXC_RST_FILT;
			regs_q[2]  <= rxc_pkg::RXC_RST_POLY;
			regs_q[3]  <= rxc_pkg::RXC_RST_SYNC;
			regs_q[4]  <= rxc_pkg::RXC_RST_RES;
			regs_q[5]  <= 8'h00;
			regs_q[6]  <= rxc_pkg::RXC_RST_OOK;
			req_q      <= '0;
			hrdata     <= 32'h00000000;
			hreadyout  <= 1'b0;
			hresp      <= rxc_pkg::RXC_HRESP_OKAY;
		end else begin
			regs_q     <= regs_d;
			req_q      <= req_d;
			hrdata     <= hrdata_d;
			hreadyout  <= 1'b1; // Zero wait states
			hresp      <= rxc_pkg::RXC_HRESP_OKAY;
		end
	end

	// ======================================================================
	// Field views
	logic [7:0] r_alert;
	logic [7:0] r_filt;
	logic [7:0] r_poly;
	logic [7:0] r_sync;
	logic [7:0] r_ook;
	logic [1:0] sync_size;
	logic [1:0] sync_tol;
	logic [2:0] floor_rate;

	// Plain views of the stored bytes
	always_comb begin
		r_alert    = regs_q[0];
		r_filt     = regs_q[1];
		r_poly     = regs_q[2];
		r_sync     = regs_q[3];
		r_ook      = regs_q[6];
		sync_size  = r_sync[rxc_pkg::RXC_SYNC_SIZE_LSB +: 2];
		sync_tol   = r_sync[rxc_pkg::RXC_SYNC_TOL_LSB +: 2];
		floor_rate = r_ook[rxc_pkg::RXC_OOK_RATE_LSB +: 3];
	end

	// ======================================================================
	// Sync word matcher
	logic [31:0] shreg_q;
	logic [31:0] shreg_d;
	logic [5:0]  nbits_q;
	logic [5:0]  nbits_d;
	logic        match_d;
	logic [4:0]  drop;
	logic [31:0] expect_w;
	logic [31:0] mask_w;
	logic [5:0]  need;
	logic [5:0]  errs;

	// Newest bit enters at bit 0; count saturates at 32
	always_comb begin
		shreg_d = shreg_q;
		nbits_d = nbits_q;
		if (rx_bit_valid) begin
			shreg_d = {shreg_q[30:0], rx_bit};
			if (nbits_q != 6'h20) begin
				nbits_d = nbits_q + 6'h01;
			end
		end
		drop     = {~sync_size, 3'h0};
		need     = 6'({sync_size, 3'h0}) + 6'h08;
		// low bytes dropped below 32 bits
		expect_w = sync_word >> drop;
		mask_w   = 32'hFFFFFFFF >> drop;
		errs     = ones((expect_w ^ shreg_d) & mask_w);
		match_d  = rx_bit_valid && r_sync[rxc_pkg::RXC_SYNC_ON_BIT] && (nbits_d >= need)
			&& (errs <= {4'h0, sync_tol});
	end

	// Match flag is registered: high for one cycle per matching valid bit
	always_ff @(posedge clk) begin
		if (!rstn) begin
			shreg_q    <= 32'h00000000;
			nbits_q    <= 6'h00;
			sync_match <= 1'b0;
		end else begin
			shreg_q    <= shreg_d;
			nbits_q    <= nbits_d;
			sync_match <= match_d;
		end
	end

	// ======================================================================
	// Onoff floor decrement pacing
	logic [3:0] pace_q;
	logic [3:0] pace_d;
	logic [3:0] period;
	logic       pace_tick;
	logic       dec_d;

	// Slow codes count chip periods, fast codes count sixteenths of a chip
	// Limitation: the counter is not cleared on a rate change
	always_comb begin
		if (!floor_rate[2]) begin
			pace_tick = chip_tick;
			period    = 4'((5'h01 << floor_rate[1:0]) - 5'h01);
		end else begin
			pace_tick = chip_sub_tick;
			period    = 4'((5'h10 >> ({1'b0, floor_rate[1:0]} + 3'h1)) - 5'h01);
		end
		pace_d = pace_q;
		dec_d  = 1'b0;
		if (pace_tick) begin
			if (pace_q >= period) begin
				pace_d = 4'h0;
				dec_d  = 1'b1;
			end else begin
				pace_d = pace_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pace_q          <= 4'h0;
			onoff_floor_dec <= 1'b0;
		end else begin
			pace_q          <= pace_d;
			onoff_floor_dec <= dec_d;
		end
	end

	// ======================================================================
	// Registered control outputs
	logic [3:0] lp_d;
	logic [3:0] cut_d;
	logic [3:0] ctr_d;
	logic       img_d;
	logic       bsa_d;
	logic       above_d;
	logic [3:0] step_d;
	logic [1:0] avg_d;

	always_comb begin
		lp_d    = r_filt[rxc_pkg::RXC_FILT_LP_LSB +: 4];
		cut_d   = r_filt[rxc_pkg::RXC_FILT_CUT_LSB +: 4];
		ctr_d   = r_poly[rxc_pkg::RXC_POLY_CTR_LSB +: 4];
		img_d   = ook_rx_mode && r_sync[rxc_pkg::RXC_SYNC_IMG_BIT];
		bsa_d   = continuous_rx_mode && !r_sync[rxc_pkg::RXC_SYNC_BSOFF_BIT];
		above_d = strength_in > r_alert;
		step_d  = step_half_db(r_ook[rxc_pkg::RXC_OOK_STEP_LSB +: 3]);
		avg_d   = r_ook[rxc_pkg::RXC_OOK_CUT_LSB +: 2];
	end

	// Copies lag their register by one cycle so every output leaves a flop
	always_ff @(posedge clk) begin
		if (!rstn) begin
			lowpass_bw_sel       <= rxc_pkg::RXC_RST_FILT[7:4];
			channel_filter_cut   <= rxc_pkg::RXC_RST_FILT[3:0];
			image_filter_centre  <= rxc_pkg::RXC_RST_POLY[7:4];
			image_filter_on      <= 1'b0;
			bitsync_active       <= 1'b0;
			strength_above       <= 1'b0;
			onoff_floor_step     <= 4'h1;
			onoff_average_cutoff <= rxc_pkg::RXC_RST_OOK[1:0];
		end else begin
			lowpass_bw_sel       <= lp_d;
			channel_filter_cut   <= cut_d;
			image_filter_centre  <= ctr_d;
			image_filter_on      <= img_d;
			bitsync_active       <= bsa_d;
			strength_above       <= above_d;
			onoff_floor_step     <= step_d;
			onoff_average_cutoff <= avg_d;
		end
	end

	// hsize is not checked: only whole-word transfers reach this slave
	logic unused_ok;
	always_comb begin
		unused_ok = (hsize == rxc_pkg::RXC_HSIZE_WORD) | hwdata[31] | (|req_q.idx[7:3]);
	end

endmodule : rxc_rx_config

// ==== verilog/rxc_pkg.sv ====
// Purpose: Shared constants and types for the receiver configuration register bank
// Assumes: AHB-Lite word access, register index times four gives the byte address
// Notes:   Offsets, field positions and register reset values live here; slot 5 and floor step resets are literals
// ==========================================================================
// Package
package rxc_pkg;

	// ======================================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] RXC_IDX_ALERT    = 8'h0F; // strength_alert_level
	localparam logic [7:0] RXC_IDX_FILT     = 8'h10; // rx_filter_bandwidth
	localparam logic [7:0] RXC_IDX_POLY     = 8'h11; // polyphase_center_cfg
	localparam logic [7:0] RXC_IDX_SYNC     = 8'h12; // sync_detect_cfg
	localparam logic [7:0] RXC_IDX_RES      = 8'h13; // rx_reserved_cfg
	localparam logic [7:0] RXC_IDX_STRENGTH = 8'h14; // signal_strength_reading
	localparam logic [7:0] RXC_IDX_OOK      = 8'h15; // ook_threshold_cfg
	localparam logic [7:0] RXC_IDX_FIRST    = 8'h0F;
	localparam logic [7:0] RXC_IDX_LAST     = 8'h15;
	localparam int         RXC_NREG         = 7;

	// ======================================================================
	// Field positions
	localparam int RXC_FILT_LP_LSB    = 4; // lowpass_bw_sel [7:4]
	localparam int RXC_FILT_CUT_LSB   = 0; // channel_filter_cut [3:0]
	localparam int RXC_POLY_CTR_LSB   = 4; // image_filter_centre [7:4]
	localparam int RXC_SYNC_IMG_BIT   = 7;
	localparam int RXC_SYNC_BSOFF_BIT = 6;
	localparam int RXC_SYNC_ON_BIT    = 5;
	localparam int RXC_SYNC_SIZE_LSB  = 3; // [4:3]
	localparam int RXC_SYNC_TOL_LSB   = 1; // [2:1]
	localparam int RXC_OOK_STEP_LSB   = 5; // [7:5]
	localparam int RXC_OOK_RATE_LSB   = 2; // [4:2]
	localparam int RXC_OOK_CUT_LSB    = 0; // [1:0]

	// ======================================================================
	// Reset values
	localparam logic [7:0] RXC_RST_ALERT = 8'h00;
	localparam logic [7:0] RXC_RST_FILT  = 8'h03; // lowpass 0000, cut 0011
	localparam logic [7:0] RXC_RST_POLY  = 8'h38; // centre 0011, reserved 1000
	localparam logic [7:0] RXC_RST_SYNC  = 8'h18; // 32-bit word, all else 0
	localparam logic [7:0] RXC_RST_RES   = 8'h07;
	localparam logic [7:0] RXC_RST_OOK   = 8'h00;

	// ======================================================================
	// AHB constants
	localparam logic [1:0] RXC_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] RXC_HSIZE_WORD    = 3'h2;
	localparam logic       RXC_HRESP_OKAY    = 1'b0;

	// Captured address phase
	typedef struct packed {
		logic       wr;   // Write of a mapped register pending
		logic [7:0] idx;  // Register slot (index less RXC_IDX_FIRST)
	} rxc_req_t;

endpackage : rxc_pkg

// ==== tb/rxc_rx_config_checker.sv ====
// Purpose: Port assertions for rxc_rx_config
// Assumes: hready follows hreadyout
// Notes:   Shadow bytes predict the field outputs
`timescale 1ns/1ps
// ====
// Checker
module rxc_rx_config_checker (
	// Clock, reset, bus
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	// Receiver side
	input wire logic [7:0]  strength_in,
	input wire logic        ook_rx_mode,
	input wire logic        continuous_rx_mode,
	input wire logic        rx_bit_valid,
	input wire logic        chip_tick,
	input wire logic [3:0]  lowpass_bw_sel,
	input wire logic [3:0]  channel_filter_cut,
	input wire logic        image_filter_on,
	input wire logic        bitsync_active,
	input wire logic        sync_match,
	input wire logic [3:0]  onoff_floor_step,
	input wire logic        onoff_floor_dec,
	input wire logic [1:0]  onoff_average_cutoff
);
	logic [7:0] sh_q [8];
	logic       wp_q;
	logic [2:0] wi_q;
	// Half dB units; codes above 3 step by whole dB
	function automatic logic [3:0] stp(input logic [2:0] c);
		return c[2] ? {c, 1'b0} - 4'h2 : {1'b0, c} + 4'h1;
	endfunction : stp
	// Shadow of written bytes; index unreset since wp_q gates it
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wp_q <= 1'b0;
			sh_q <= '{8'h03, 8'h38, 8'h18, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
		end else begin
			wp_q <= hsel && hready && htrans == 2'h2 && hwrite && haddr[31:5] == 27'h2 && haddr[1:0] == 2'h0;
			wi_q <= haddr[4:2];
			if (wp_q) sh_q[wi_q] <= hwdata[7:0];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Read of the level register
	sequence s_rd_level;
		hsel && hready && htrans == 2'h2 && !hwrite && haddr == 32'h50;
	endsequence
	property p_rd_level; s_rd_level |=> hrdata == {24'h0, $past(strength_in)}; endproperty
	a_rd_level: assert property (p_rd_level) else $error("level read");
	property p_match; sync_match |-> $past(rx_bit_valid && sh_q[2][5]); endproperty
	a_match: assert property (p_match) else $error("stray match");
	property p_bitsync; $past(rstn) |-> bitsync_active == $past(continuous_rx_mode && !sh_q[2][6]); endproperty
	a_bitsync: assert property (p_bitsync) else $error("bitsync");
	property p_image; $past(rstn) |-> image_filter_on == $past(ook_rx_mode && sh_q[2][7]); endproperty
	a_image: assert property (p_image) else $error("image filter");
	property p_step; $past(rstn) |-> onoff_floor_step == stp($past(sh_q[5][7:5])); endproperty
	a_step: assert property (p_step) else $error("floor step");
	property p_dec; $past(rstn) && $past(sh_q[5][4:2]) == 3'h0 |-> onoff_floor_dec == $past(chip_tick); endproperty
	a_dec: assert property (p_dec) else $error("floor pacing");
	property p_cut; $past(rstn) |-> onoff_average_cutoff == $past(sh_q[5][1:0]); endproperty
	a_cut: assert property (p_cut) else $error("average cutoff");
	property p_filt; $past(rstn) |-> {lowpass_bw_sel, channel_filter_cut} == $past(sh_q[0]); endproperty
	a_filt: assert property (p_filt) else $error("filter fields");
endmodule : rxc_rx_config_checker

bind rxc_rx_config rxc_rx_config_checker u_chk (
	.clk                  (clk),
	.rstn                 (rstn),
	.hsel                 (hsel),
	.haddr                (haddr),
	.htrans               (htrans),
	.hwrite               (hwrite),
	.hwdata               (hwdata),
	.hready               (hready),
	.hrdata               (hrdata),
	.strength_in          (strength_in),
	.ook_rx_mode          (ook_rx_mode),
	.continuous_rx_mode   (continuous_rx_mode),
	.rx_bit_valid         (rx_bit_valid),
	.chip_tick            (chip_tick),
	.lowpass_bw_sel       (lowpass_bw_sel),
	.channel_filter_cut   (channel_filter_cut),
	.image_filter_on      (image_filter_on),
	.bitsync_active       (bitsync_active),
	.sync_match           (sync_match),
	.onoff_floor_step     (onoff_floor_step),
	.onoff_floor_dec      (onoff_floor_dec),
	.onoff_average_cutoff (onoff_average_cutoff)
);

// ==== tb/test_rx_config_registers.sv ====
// Purpose: Self-checking bench for rxc_rx_config
// Assumes: hready tied to hreadyout
// Notes:   Expectations typed from the field tables
`timescale 1ns/1ps
// ====
// Bench
module test_rx_config_registers;
	`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
		$display("[ERR] %0t got %h exp %h", $time, a, e); end end
	logic        clk, rstn, hsel, hwrite, hreadyout, hresp, rx_bit, rx_bit_valid, chip_tick, chip_sub_tick;
	logic        ook_rx_mode, continuous_rx_mode, image_filter_on, bitsync_active, sync_match, strength_above;
	logic        onoff_floor_dec;
	logic [1:0]  htrans, onoff_average_cutoff;
	logic [2:0]  hsize;
	logic [3:0]  lowpass_bw_sel, channel_filter_cut, image_filter_centre, onoff_floor_step;
	logic [7:0]  strength_in;
	logic [31:0] haddr, hwdata, hrdata, sync_word, rd;
	int          num_errors = 0;
	int          n_compared = 0;
	// Device; the only slave drives hready
	rxc_rx_config DUT (
		.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .strength_in(strength_in), .ook_rx_mode(ook_rx_mode),
		.continuous_rx_mode(continuous_rx_mode), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
		.sync_word(sync_word), .chip_tick(chip_tick), .chip_sub_tick(chip_sub_tick),
		.lowpass_bw_sel(lowpass_bw_sel), .channel_filter_cut(channel_filter_cut),
		.image_filter_centre(image_filter_centre), .image_filter_on(image_filter_on),
		.bitsync_active(bitsync_active), .sync_match(sync_match), .strength_above(strength_above),
		.onoff_floor_step(onoff_floor_step), .onoff_floor_dec(onoff_floor_dec),
		.onoff_average_cutoff(onoff_average_cutoff)
	);
	// Clock and watchdog; the run needs under 3000 cycles
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		num_errors++;
		$display("[ERR] %0t watchdog", $time);
		conclude();
	end
	// One transfer; each phase held until hready is seen high
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= rxc_pkg::RXC_HTRANS_NONSEQ;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic rdchk(input logic [31:0] a, input logic [7:0] e);
		ahb(1'b0, a, 32'h0);
		`CHK(rd, ({24'h0, e}))
	endtask : rdchk
	// Registered outputs land one edge after their cause
	task automatic settle;
		@(posedge clk);
		#1;
	endtask : settle
	// First byte first, a strobe every second cycle
	task automatic send(input logic [31:0] v, input int n);
		for (int i = 31; i > 31 - n; i--) begin
			@(posedge clk);
			rx_bit <= v[i];
			rx_bit_valid <= 1'b1;
			@(posedge clk);
			rx_bit_valid <= 1'b0;
		end
		#1;
	endtask : send
	task automatic conclude;
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	// Reset values and an unmapped read
	task automatic t_reset;
		logic [7:0] e [7];
		e = '{8'h00, 8'h03, 8'h38, 8'h18, 8'h07, 8'h5A, 8'h00};
		settle();
		`CHK(channel_filter_cut, 4'h3)
		`CHK(image_filter_centre, 4'h3)
		`CHK(bitsync_active, 1'b1)
		for (int i = 0; i < 7; i++) rdchk(32'h3C + 32'(4 * i), e[i]);
		rdchk(32'h400, 8'h00);
		`CHK(({hreadyout, hresp}), 2'h2)
		$display("reset done");
	endtask : t_reset
	// Back-to-back writes reach the fields; ook mode gates the image filter enable
	task automatic t_rw;
		ahb(1'b1, 32'h40, 32'hA5);
		ahb(1'b1, 32'h44, 32'h7C);
		ahb(1'b1, 32'h48, 32'hC0);
		ahb(1'b1, 32'h3C, 32'h40);
		strength_in <= 8'h41;
		settle();
		`CHK(({lowpass_bw_sel, channel_filter_cut}), 8'hA5)
		`CHK(image_filter_centre, 4'h7)
		`CHK(image_filter_on, 1'b1)
		`CHK(bitsync_active, 1'b0)
		`CHK(strength_above, 1'b1)
		rdchk(32'h44, 8'h7C);
		ook_rx_mode <= 1'b0;
		strength_in <= 8'h40;
		settle();
		`CHK(image_filter_on, 1'b0)
		`CHK(strength_above, 1'b0)
		rdchk(32'h50, 8'h40); // level is only read
		$display("write done");
	endtask : t_rw
	// Floor step and pacing for every code, cutoff for codes 0 and 3
	task automatic t_ook;
		logic [3:0] s [8];
		int         n;
		s = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC};
		for (int c = 0; c < 8; c++) begin
			ahb(1'b1, 32'h54, 32'(c * 36 + c % 2 * 3));
			rdchk(32'h54, 8'(c * 36 + c % 2 * 3));
			settle();
			`CHK(onoff_floor_step, s[c])
			`CHK(onoff_average_cutoff, 2'(c % 2 * 3))
			n = 0;
			repeat (16) begin
				@(posedge clk);
				if (c < 4) chip_tick <= 1'b1;
				else chip_sub_tick <= 1'b1;
				@(posedge clk);
				chip_tick <= 1'b0;
				chip_sub_tick <= 1'b0;
				repeat (3) begin
					@(posedge clk);
					n += onoff_floor_dec;
				end
			end
			`CHK(n, (c < 4 ? 16 >> c : 2 << (c - 4)))
		end
		$display("floor done");
	endtask : t_ook
	// Each tolerance, errors at and beyond it; short word; matching off
	task automatic t_sync;
		logic [31:0] m [5];
		m = '{32'h0, 32'h1, 32'h101, 32'h10101, 32'h1010101};
		for (int t = 0; t < 4; t++) begin
			for (int e = t; e < t + 2; e++) begin
				ahb(1'b1, 32'h48, 32'h38 + 32'(2 * t));
				send(sync_word ^ m[e], 32);
				`CHK(sync_match, 1'(e <= t))
			end
		end
		ahb(1'b1, 32'h48, 32'h30);
		send(sync_word, 24);
		`CHK(sync_match, 1'b1)
		ahb(1'b1, 32'h48, 32'h18);
		send(sync_word, 32);
		`CHK(sync_match, 1'b0)
		`CHK(bitsync_active, 1'b1)
		@(posedge clk);
		continuous_rx_mode <= 1'b0;
		settle();
		`CHK(bitsync_active, 1'b0)
		$display("sync done");
	endtask : t_sync
	// Main sequence
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, rx_bit, rx_bit_valid, chip_tick, chip_sub_tick} = '0;
		rstn = 1'b0;
		hsize = rxc_pkg::RXC_HSIZE_WORD;
		strength_in = 8'h5A;
		sync_word = 32'hA5C30F96;
		ook_rx_mode = 1'b1;
		continuous_rx_mode = 1'b1;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_rw();
		t_ook();
		t_sync();
		conclude();
	end
endmodule : test_rx_config_registers
